//--- rtl/uartb_pkg.sv
// Package: constants and carrier types for the USB-to-UART pass-through bridge
package uartb_pkg;

  // ---------------------------------------------------------------
  // Clock and baud
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25000000;
  localparam logic [2:0] BAUD_115200 = 3'h0;
  localparam logic [2:0] BAUD_57600 = 3'h1;
  localparam logic [2:0] BAUD_38400 = 3'h2;
  localparam logic [2:0] BAUD_19200 = 3'h3;
  localparam logic [2:0] BAUD_9600 = 3'h4;
  localparam int unsigned RATE_115200 = 115200;
  localparam int unsigned RATE_57600 = 57600;
  localparam int unsigned RATE_38400 = 38400;
  localparam int unsigned RATE_19200 = 19200;
  localparam int unsigned RATE_9600 = 9600;
  // Oversampling: 16 ticks per bit
  localparam int unsigned OVERSAMPLE = 16;
  localparam logic [3:0] MID_TICK = 4'h7;
  localparam logic [3:0] LAST_TICK = 4'hf;
  // Tick divisors, rounded down so that no rate is slow
  localparam logic [7:0] DIV_115200 = 8'(CLK_HZ / (RATE_115200 * OVERSAMPLE));
  localparam logic [7:0] DIV_57600 = 8'(CLK_HZ / (RATE_57600 * OVERSAMPLE));
  localparam logic [7:0] DIV_38400 = 8'(CLK_HZ / (RATE_38400 * OVERSAMPLE));
  localparam logic [7:0] DIV_19200 = 8'(CLK_HZ / (RATE_19200 * OVERSAMPLE));
  localparam logic [7:0] DIV_9600 = 8'(CLK_HZ / (RATE_9600 * OVERSAMPLE));

  // ---------------------------------------------------------------
  // Frame
  // ---------------------------------------------------------------
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned STOP_BITS = 1;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] SERIAL_ENDPOINT = 4'h2;

  // ---------------------------------------------------------------
  // Register map (byte offsets)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_PINSEL = 8'h08;
  localparam logic [7:0] OFF_HOSTEP = 8'h0c;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0004;
  localparam logic [31:0] PINSEL_RESET = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Receive buffering threshold for throttling
  localparam int unsigned RX_DEPTH = 16;
  localparam int unsigned RX_ALMOST = 12;

  // Control register fields
  typedef struct packed {
    logic [23:0] rsvd;
    logic audio_on;       // Audio streaming configured
    logic serial_io_on;   // Serial I/O interface configured
    logic passthru_on;    // Pass-through configured
    logic [2:0] baud_sel;
    logic [1:0] rsvd2;
  } uartb_ctrl_t;

  // Pin selection: 1 = serial function, 0 = general-purpose
  typedef struct packed {
    logic [23:0] rsvd;
    logic rts_od;         // RTS open-drain
    logic tx_od;          // TX open-drain
    logic rts_sel;
    logic cts_sel;
    logic rx_sel;
    logic tx_sel;
    logic [1:0] rsvd2;
  } uartb_pinsel_t;

  // Byte stream with endpoint tag
  typedef struct packed {
    logic [3:0] ep;
    logic [7:0] data;
  } uartb_byte_t;

  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001,
    TX_START = 4'b0010,
    TX_DATA = 4'b0100,
    TX_STOP = 4'b1000
  } uartb_tx_state_t;

endpackage : uartb_pkg

//--- rtl/uartb_rx.sv
// Receiver: centre-sampling 8N1 deserialiser
`timescale 1ns/10ps
`default_nettype none
module uartb_rx (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic tick,
  input wire logic enable,
  input wire logic rxd,
  output logic [7:0] data_ff,
  output logic valid_ff,
  output logic frame_err_ff
);
  logic busy_ff;
  logic [3:0] tcnt_ff;
  logic [3:0] bcnt_ff;
  logic stop_ff;
  logic [7:0] shift_ff;

  // ---------------------------------------------------------------
  // Framing
  // ---------------------------------------------------------------
  // Start on falling edge, sample each bit at its centre tick
  always_ff @(posedge clk) begin
    valid_ff <= 1'b0;
    frame_err_ff <= 1'b0;
    if (sys_rst || !enable) begin
      busy_ff <= 1'b0;
      tcnt_ff <= 4'h0;
      bcnt_ff <= 4'h0;
      stop_ff <= 1'b0;
      shift_ff <= 8'h00;
      data_ff <= 8'h00;
    end else if (!busy_ff) begin
      if (!rxd) begin
        busy_ff <= 1'b1;
        tcnt_ff <= 4'h0;
        bcnt_ff <= 4'h0;
        stop_ff <= 1'b0;
      end
    end else if (tick) begin
      tcnt_ff <= tcnt_ff + 4'h1;
      if (tcnt_ff == uartb_pkg::MID_TICK) begin
        if (stop_ff) begin
          busy_ff <= 1'b0;
          valid_ff <= rxd;
          frame_err_ff <= !rxd;
          data_ff <= shift_ff;
        end else if (bcnt_ff == 4'h0 && rxd) begin
          busy_ff <= 1'b0; // False start
        end else if (bcnt_ff != 4'h0) begin
          shift_ff <= {rxd, shift_ff[7:1]};
          if (bcnt_ff == uartb_pkg::BIT_LAST + 4'h1) begin
            stop_ff <= 1'b1;
          end
        end
        if (!stop_ff) begin
          bcnt_ff <= bcnt_ff + 4'h1;
        end
      end
    end
  end
endmodule : uartb_rx
`default_nettype wire

//--- rtl/uartb_bridge.sv
// Top: USB-to-UART pass-through bridge with AXI4-Lite configuration
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
`default_nettype none
module uartb_bridge #(
  parameter int unsigned RX_DEPTH = uartb_pkg::RX_DEPTH,
  parameter int unsigned RX_ALMOST = uartb_pkg::RX_ALMOST
) (
  input wire logic clk,
  input wire logic sys_rst,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Host OUT stream (bulk endpoint)
  input wire uartb_pkg::uartb_byte_t host_out,
  input wire logic host_out_valid,
  output logic host_out_ready,
  // Host IN stream (bulk endpoint)
  output uartb_pkg::uartb_byte_t host_in_ff,
  output logic host_in_valid,
  input wire logic host_in_ready,
  // Pin message protocol traffic on endpoints other than the serial one
  output uartb_pkg::uartb_byte_t pin_message_protocol_out_ff,
  output logic pin_message_protocol_valid_ff,
  // Serial pins
  output logic txd_o_ff,
  output logic txd_oe_n,
  input wire logic rxd_i,
  output logic rts_o,
  output logic rts_oe_n,
  input wire logic cts_i
);
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  uartb_pkg::uartb_ctrl_t ctrl_ff;
  uartb_pkg::uartb_pinsel_t pinsel_ff;
  logic aw_hold_ff;
  logic w_hold_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic [31:0] nxt_rdata;
  logic nxt_rd_ok;
  logic tx_overrun_ff;
  logic rx_frame_err_ff;
  logic rx_overflow_ff;
  // Derived enables
  logic uart_on;
  logic rts_on;
  logic cts_on;
  logic rate_ok;
  assign uart_on = ctrl_ff.passthru_on && pinsel_ff.tx_sel && pinsel_ff.rx_sel;
  assign rts_on = uart_on && ctrl_ff.serial_io_on && pinsel_ff.rts_sel;
  assign cts_on = uart_on && ctrl_ff.serial_io_on && pinsel_ff.cts_sel;
  // Audio allows only 9600; no audio above 19200 needs RTS
  always_comb begin
    if (ctrl_ff.audio_on) begin
      rate_ok = (ctrl_ff.baud_sel == uartb_pkg::BAUD_9600);
    end else if (ctrl_ff.baud_sel == uartb_pkg::BAUD_19200 ||
                 ctrl_ff.baud_sel == uartb_pkg::BAUD_9600) begin
      rate_ok = 1'b1;
    end else begin
      rate_ok = rts_on && ctrl_ff.baud_sel < uartb_pkg::BAUD_9600;
    end
  end
  // ---------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------
  assign s_axi_awready = !aw_hold_ff && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_ff && !s_axi_bvalid;
  // Capture address and data in either order
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else if (aw_hold_ff && w_hold_ff) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
    end
  end
  // Register update and write response
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_ff <= uartb_pkg::uartb_ctrl_t'(uartb_pkg::CTRL_RESET);
      pinsel_ff <= uartb_pkg::uartb_pinsel_t'(uartb_pkg::PINSEL_RESET);
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= uartb_pkg::RESP_OKAY;
    end else if (aw_hold_ff && w_hold_ff) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= uartb_pkg::RESP_OKAY;
      case (awaddr_ff)
        uartb_pkg::OFF_CTRL: begin
          if (wstrb_ff[0]) begin
            ctrl_ff.baud_sel <= (wdata_ff[4:2] > uartb_pkg::BAUD_9600) ?
                                uartb_pkg::BAUD_9600 : wdata_ff[4:2];
            ctrl_ff.passthru_on <= wdata_ff[5];
            ctrl_ff.serial_io_on <= wdata_ff[6];
            ctrl_ff.audio_on <= wdata_ff[7];
          end
        end
        uartb_pkg::OFF_PINSEL: begin
          if (wstrb_ff[0]) begin
            pinsel_ff.tx_sel <= wdata_ff[2];
            pinsel_ff.rx_sel <= wdata_ff[3];
            pinsel_ff.cts_sel <= wdata_ff[4];
            pinsel_ff.rts_sel <= wdata_ff[5];
            pinsel_ff.tx_od <= wdata_ff[6];
            pinsel_ff.rts_od <= wdata_ff[7];
          end
        end
        uartb_pkg::OFF_STATUS: ;
        default: begin
          s_axi_bresp <= uartb_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
  // ---------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  // Read mux
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    nxt_rd_ok = 1'b1;
    case (s_axi_araddr)
      uartb_pkg::OFF_CTRL: nxt_rdata = ctrl_ff;
      uartb_pkg::OFF_PINSEL: nxt_rdata = pinsel_ff;
      uartb_pkg::OFF_STATUS: begin
        nxt_rdata = {24'h000000, rts_o, cts_i, rx_overflow_ff, rx_frame_err_ff,
                     tx_overrun_ff, rate_ok, uart_on, host_in_valid};
      end
      uartb_pkg::OFF_HOSTEP: nxt_rdata = {28'h0000000, uartb_pkg::SERIAL_ENDPOINT};
      default: nxt_rd_ok = 1'b0;
    endcase
  end
  // Read response register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= uartb_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= nxt_rdata;
      s_axi_rresp <= nxt_rd_ok ? uartb_pkg::RESP_OKAY : uartb_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  // ---------------------------------------------------------------
  // Baud tick divider (16x)
  // ---------------------------------------------------------------
  logic [7:0] div_ff;
  logic [7:0] div_lim;
  logic tick;
  always_comb begin
    case (ctrl_ff.baud_sel)
      uartb_pkg::BAUD_115200: div_lim = uartb_pkg::DIV_115200;
      uartb_pkg::BAUD_57600: div_lim = uartb_pkg::DIV_57600;
      uartb_pkg::BAUD_38400: div_lim = uartb_pkg::DIV_38400;
      uartb_pkg::BAUD_19200: div_lim = uartb_pkg::DIV_19200;
      default: div_lim = uartb_pkg::DIV_9600;
    endcase
  end
  assign tick = (div_ff == div_lim - 8'h01);
  // Free-running shared tick
  always_ff @(posedge clk) begin
    if (sys_rst || tick) begin
      div_ff <= 8'h00;
    end else begin
      div_ff <= div_ff + 8'h01;
    end
  end
  // ---------------------------------------------------------------
  // Transmitter
  // ---------------------------------------------------------------
  uartb_pkg::uartb_tx_state_t tx_st_ff;
  logic [7:0] tx_shift_ff;
  logic [3:0] tx_tcnt_ff;
  logic [3:0] tx_bcnt_ff;
  logic cts_block;
  assign cts_block = cts_on && cts_i;
  // Take a host byte only when idle and not throttled
  assign host_out_ready = (tx_st_ff == uartb_pkg::TX_IDLE) && uart_on && !cts_block
                          && host_out.ep == uartb_pkg::SERIAL_ENDPOINT;
  // Serialiser state
  always_ff @(posedge clk) begin
    if (sys_rst || !uart_on) begin
      tx_st_ff <= uartb_pkg::TX_IDLE;
      tx_shift_ff <= 8'h00;
      tx_tcnt_ff <= 4'h0;
      tx_bcnt_ff <= 4'h0;
      txd_o_ff <= 1'b1;
    end else begin
      case (tx_st_ff)
        uartb_pkg::TX_IDLE: begin
          txd_o_ff <= 1'b1;
          if (host_out_valid && host_out_ready) begin
            tx_shift_ff <= host_out.data;
            tx_st_ff <= uartb_pkg::TX_START;
            tx_tcnt_ff <= 4'h0;
          end
        end
        uartb_pkg::TX_START: begin
          txd_o_ff <= 1'b0;
          if (tick) begin
            tx_tcnt_ff <= tx_tcnt_ff + 4'h1;
            if (tx_tcnt_ff == uartb_pkg::LAST_TICK) begin
              tx_st_ff <= uartb_pkg::TX_DATA;
              tx_bcnt_ff <= 4'h0;
            end
          end
        end
        uartb_pkg::TX_DATA: begin
          txd_o_ff <= tx_shift_ff[0];
          if (tick) begin
            tx_tcnt_ff <= tx_tcnt_ff + 4'h1;
            if (tx_tcnt_ff == uartb_pkg::LAST_TICK) begin
              tx_shift_ff <= {1'b0, tx_shift_ff[7:1]};
              tx_bcnt_ff <= tx_bcnt_ff + 4'h1;
              if (tx_bcnt_ff == uartb_pkg::BIT_LAST) begin
                tx_st_ff <= uartb_pkg::TX_STOP;
              end
            end
          end
        end
        uartb_pkg::TX_STOP: begin
          txd_o_ff <= 1'b1;
          if (tick) begin
            tx_tcnt_ff <= tx_tcnt_ff + 4'h1;
            if (tx_tcnt_ff == uartb_pkg::LAST_TICK) begin
              tx_st_ff <= uartb_pkg::TX_IDLE;
            end
          end
        end
        default: tx_st_ff <= uartb_pkg::TX_IDLE;
      endcase
    end
  end
  // Open-drain TX releases for high
  assign txd_oe_n = !(uart_on && (!pinsel_ff.tx_od || !txd_o_ff));
  // Other endpoints go to the pin message port
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_message_protocol_out_ff <= '0;
      pin_message_protocol_valid_ff <= 1'b0;
      tx_overrun_ff <= 1'b0;
    end else begin
      pin_message_protocol_valid_ff <= host_out_valid &&
                                       host_out.ep != uartb_pkg::SERIAL_ENDPOINT;
      pin_message_protocol_out_ff <= host_out;
      if (host_out_valid && !uart_on && host_out.ep == uartb_pkg::SERIAL_ENDPOINT) begin
        tx_overrun_ff <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Receiver and receive buffer
  // ---------------------------------------------------------------
  logic [7:0] rx_data;
  logic rx_valid;
  logic rx_ferr;
  uartb_rx u_rx (
    .clk(clk),
    .sys_rst(sys_rst),
    .tick(tick),
    .enable(uart_on),
    .rxd(rxd_i),
    .data_ff(rx_data),
    .valid_ff(rx_valid),
    .frame_err_ff(rx_ferr)
  );
  localparam int unsigned AW = $clog2(RX_DEPTH);
  logic [7:0] rx_mem [RX_DEPTH];
  logic [AW:0] wr_ptr_ff;
  logic [AW:0] rd_ptr_ff;
  logic [AW:0] level;
  logic rx_full;
  assign level = wr_ptr_ff - rd_ptr_ff;
  assign rx_full = (level == (AW + 1)'(RX_DEPTH));
  assign host_in_valid = (level != '0);
  // Buffer pointers, storage, error flags
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      rx_overflow_ff <= 1'b0;
      rx_frame_err_ff <= 1'b0;
    end else begin
      if (rx_valid && !rx_full) begin
        rx_mem[wr_ptr_ff[AW-1:0]] <= rx_data;
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (rx_valid && rx_full) begin
        rx_overflow_ff <= 1'b1;
      end
      if (rx_ferr) begin
        rx_frame_err_ff <= 1'b1;
      end
      if (host_in_valid && host_in_ready) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
    end
  end
  // Head byte tagged with the serial endpoint
  always_comb begin
    host_in_ff.ep = uartb_pkg::SERIAL_ENDPOINT;
    host_in_ff.data = rx_mem[rd_ptr_ff[AW-1:0]];
  end
  // RTS low while room remains, high near full
  assign rts_o = (level >= (AW + 1)'(RX_ALMOST));
  assign rts_oe_n = !(rts_on && (!pinsel_ff.rts_od || !rts_o));
endmodule : uartb_bridge
`default_nettype wire

//--- verif/uartb_bridge_assertions.sv
// Checker: port-level properties of the pass-through bridge
`timescale 1ns/10ps
`default_nettype none
module uartb_bridge_assertions (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire uartb_pkg::uartb_byte_t host_out,
  input wire logic host_out_valid,
  input wire logic host_out_ready,
  input wire uartb_pkg::uartb_byte_t host_in_ff,
  input wire logic host_in_valid,
  input wire uartb_pkg::uartb_byte_t pin_message_protocol_out_ff,
  input wire logic pin_message_protocol_valid_ff,
  input wire logic txd_o_ff,
  input wire logic rts_o
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // --------------------------------------------------------------
  // Port properties
  // --------------------------------------------------------------
  // Start bit follows a take
  property p_tx_start;
    host_out_valid && host_out_ready |=> ##1 !txd_o_ff [*8];
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("start bit missing");
  // No glitch on txd
  property p_bit_len;
    $changed(txd_o_ff) |=> $stable(txd_o_ff) [*8];
  endproperty
  a_bit_len: assert property (p_bit_len) else $error("short bit on txd");
  // Take only on idle line
  property p_ready_idle;
    host_out_ready |-> txd_o_ff;
  endproperty
  a_ready_idle: assert property (p_ready_idle) else $error("ready mid frame");
  // RTS low when empty
  property p_rts_empty;
    !host_in_valid |-> !rts_o;
  endproperty
  a_rts_empty: assert property (p_rts_empty) else $error("rts high when empty");
  property p_ready_ep;
    host_out_ready |-> host_out.ep == uartb_pkg::SERIAL_ENDPOINT;
  endproperty
  a_ready_ep: assert property (p_ready_ep) else $error("foreign endpoint taken");
  property p_in_ep;
    host_in_valid |-> host_in_ff.ep == uartb_pkg::SERIAL_ENDPOINT;
  endproperty
  a_in_ep: assert property (p_in_ep) else $error("wrong IN endpoint");
  // Pin messages pass unchanged
  property p_pmsg;
    host_out_valid && host_out.ep != uartb_pkg::SERIAL_ENDPOINT |=>
      pin_message_protocol_valid_ff && pin_message_protocol_out_ff == $past(host_out);
  endproperty
  a_pmsg: assert property (p_pmsg) else $error("pin message lost");
  property p_ep_read;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == uartb_pkg::OFF_HOSTEP |=>
      s_axi_rvalid && s_axi_rdata == 32'(uartb_pkg::SERIAL_ENDPOINT);
  endproperty
  a_ep_read: assert property (p_ep_read) else $error("endpoint read wrong");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
endmodule : uartb_bridge_assertions

bind uartb_bridge uartb_bridge_assertions u_chk (.clk, .sys_rst, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .s_axi_bvalid, .s_axi_bready, .host_out, .host_out_valid, .host_out_ready,
  .host_in_ff, .host_in_valid, .pin_message_protocol_out_ff,
  .pin_message_protocol_valid_ff, .txd_o_ff, .rts_o);
`default_nettype wire

//--- verif/uartb_far_dev.sv
// Far-side serial device model: sends on rxd, decodes txd
`timescale 1ns/10ps
`default_nettype none
module uartb_far_dev #(
  parameter int BIT = 208
) (
  input wire logic clk,
  input wire logic txd,
  input wire logic rts_n,
  output logic rxd,
  output logic cts_n
);
  logic [7:0] rx_q[$];

  initial begin
    rxd = 1'b1;
    cts_n = 1'b0;
  end

  // Send one frame after waiting while throttled
  task automatic send(input logic [7:0] b);
    int i;
    i = 0;
    while (rts_n !== 1'b0 && i < 100000) begin
      @(posedge clk);
      i++;
    end
    for (int k = 0; k < 10; k++) begin
      rxd <= (k == 0) ? 1'b0 : (k == 9) ? 1'b1 : b[k - 1];
      repeat (BIT) @(posedge clk);
    end
  endtask : send

  // Decode txd at bit centres
  always begin : rx_proc
    logic [7:0] v;
    @(negedge txd);
    repeat (BIT / 2) @(posedge clk);
    for (int k = 0; k < 8; k++) begin
      repeat (BIT) @(posedge clk);
      v[k] = txd;
    end
    repeat (BIT) @(posedge clk);
    if (txd) rx_q.push_back(v);
  end
endmodule : uartb_far_dev
`default_nettype wire

//--- verif/uartb_bridge_tb.sv
// Testbench: self-checking run of the pass-through bridge
`timescale 1ns/10ps
`default_nettype none
module uartb_bridge_tb;
  localparam int LIM = 30000;
  localparam int BIT = 16 * int'(uartb_pkg::DIV_115200);
  logic clk = 1'b0;
  logic sys_rst;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  uartb_pkg::uartb_byte_t host_out, host_in_ff, pmsg;
  logic host_out_valid, host_out_ready, host_in_valid, host_in_ready, pmsg_valid;
  logic txd_o_ff, txd_oe_n, rts_o, rts_oe_n, rxd, cts_n;
  wire txd_w = txd_oe_n ? 1'b1 : txd_o_ff;
  wire rts_w = rts_oe_n ? 1'b1 : rts_o;
  int n_fail = 0;
  int total_checks = 0;
  integer seed;
  logic [7:0] txb[4], rxb[4], d;
  logic [7:0] q[$];
  int i;

  always #20 clk = ~clk;

  uartb_bridge DUT (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .host_out, .host_out_valid,
    .host_out_ready, .host_in_ff, .host_in_valid, .host_in_ready,
    .pin_message_protocol_out_ff(pmsg), .pin_message_protocol_valid_ff(pmsg_valid),
    .txd_o_ff, .txd_oe_n, .rxd_i(rxd), .rts_o, .rts_oe_n, .cts_i(cts_n));
  uartb_far_dev #(.BIT(BIT)) far (.clk, .txd(txd_w), .rts_n(rts_w), .rxd, .cts_n);

  // ---------------------------------------------------------------
  // Checking and closing
  // ---------------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic tmo(input int n);
    if (n >= LIM) begin
      n_fail++;
      $display("mismatch at %0t: wait limit got %h exp %h", $time, n, LIM);
      end_of_test();
    end
  endtask : tmo

  // Control word for a given rate
  function automatic logic [31:0] ctrl_val(input logic [2:0] b);
    return {24'h0, 1'b0, 1'b1, 1'b1, b, 2'b00};
  endfunction : ctrl_val
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < LIM);
    tmo(n);
    chk(32'(s_axi_bresp), 32'(uartb_pkg::RESP_OKAY));
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] er = uartb_pkg::RESP_OKAY);
    int n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < LIM);
    tmo(n);
    chk(s_axi_rdata, e);
    chk(32'(s_axi_rresp), 32'(er));
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask : rdc

  task automatic put(input logic [7:0] v);
    int n = 0;
    host_out <= {uartb_pkg::SERIAL_ENDPOINT, v};
    host_out_valid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (host_out_ready !== 1'b1 && n < LIM);
    tmo(n);
    host_out_valid <= 1'b0;
    @(posedge clk);
  endtask : put

  task automatic get(output logic [7:0] v);
    int n = 0;
    host_in_ready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (host_in_valid !== 1'b1 && n < LIM);
    tmo(n);
    v = host_in_ff.data;
    host_in_ready <= 1'b0;
    @(posedge clk);
  endtask : get

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 32'h058ed6db;
    sys_rst = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    host_out = '0;
    host_out_valid = 1'b0;
    host_in_ready = 1'b0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rdc(uartb_pkg::OFF_CTRL, uartb_pkg::CTRL_RESET);
    rdc(uartb_pkg::OFF_PINSEL, uartb_pkg::PINSEL_RESET);
    rdc(uartb_pkg::OFF_HOSTEP, 32'(uartb_pkg::SERIAL_ENDPOINT));
    rdc(8'h10, 32'h0, uartb_pkg::RESP_SLVERR);
    // All five rates, ending on the fastest
    for (int b = 4; b >= 0; b--) begin
      wr(uartb_pkg::OFF_CTRL, ctrl_val(3'(b)));
      rdc(uartb_pkg::OFF_CTRL, ctrl_val(3'(b)));
    end
    // TX pin alone: serial off
    wr(uartb_pkg::OFF_PINSEL, 32'h0000_0004);
    host_out <= {uartb_pkg::SERIAL_ENDPOINT, 8'h5a};
    host_out_valid <= 1'b1;
    repeat (20) @(posedge clk);
    chk(32'(host_out_ready), 32'h0);
    chk(32'(txd_oe_n), 32'h1);
    // Foreign endpoint goes to pin messages
    host_out <= {4'h3, 8'hc3};
    @(posedge clk);
    host_out_valid <= 1'b0;
    @(posedge clk);
    chk({19'h0, pmsg_valid, pmsg}, {19'h0, 1'b1, 4'h3, 8'hc3});
    wr(uartb_pkg::OFF_PINSEL, 32'h0000_003c);
    rdc(uartb_pkg::OFF_STATUS, 32'h0000_000e);
    for (int k = 0; k < 4; k++) begin
      txb[k] = (k == 1) ? 8'h00 : (k == 2) ? 8'hff : 8'($random(seed));
      rxb[k] = (k == 1) ? 8'hff : (k == 2) ? 8'h00 : 8'($random(seed));
    end
    // Throttled: line stays idle
    far.cts_n <= 1'b1;
    host_out <= {uartb_pkg::SERIAL_ENDPOINT, txb[0]};
    host_out_valid <= 1'b1;
    repeat (3 * BIT) @(posedge clk);
    chk(32'(txd_o_ff), 32'h1);
    chk(32'(host_out_ready), 32'h0);
    host_out_valid <= 1'b0;
    far.cts_n <= 1'b0;
    @(posedge clk);
    // Both directions at once
    fork
      for (int k = 0; k < 4; k++) put(txb[k]);
      for (int k = 0; k < 4; k++) far.send(rxb[k]);
      for (int k = 0; k < 4; k++) begin
        get(d);
        chk(32'(d), 32'(rxb[k]));
      end
    join
    i = 0;
    while (far.rx_q.size() < 4 && i < LIM) begin
      @(posedge clk);
      i++;
    end
    tmo(i);
    for (int k = 0; k < 4; k++) chk(32'(far.rx_q.pop_front()), 32'(txb[k]));
    // Fill to threshold, then drain
    for (int k = 0; k < int'(uartb_pkg::RX_ALMOST); k++) begin
      q.push_back(8'($random(seed)));
      far.send(q[k]);
    end
    repeat (4) @(posedge clk);
    chk(32'(rts_o), 32'h1);
    for (int k = 0; k < int'(uartb_pkg::RX_ALMOST); k++) begin
      get(d);
      chk(32'(d), 32'(q[k]));
    end
    chk(32'(rts_o), 32'h0);
    end_of_test();
  end
endmodule : uartb_bridge_tb
`default_nettype wire
